// ### hdl/sfrcp_port.sv
// Slave FIFO port: four endpoint FIFOs read, written and committed by an external master.
// What this block does
// - Output enable only drives bus, never pops.
// - Current entry prefetched, shown on output enable.
// - Read needs chip select and read strobe.
// - Read edge advances pointer, shows next entry.
// - Data driven only while output enable asserted.
// - Burst read advances one entry per edge.
// - Auto mode commits at programmed length.
// - Too-early commit after auto commit is lost.
// - Write edge stores word, advances, updates flags.
`timescale 1ns/100ps
module sfrcp_port
  import sfrcp_pkg::*;
#(
  parameter int DATA_W = SFRCP_DATA_W,
  parameter int DEPTH = SFRCP_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Master pins, outside this clock domain
  input wire logic interface_clock,
  input wire logic [SFRCP_SEL_W-1:0] fifo_select,
  input wire sfrcp_ctl_s ctl_pins,
  input wire logic [DATA_W-1:0] data_in,
  // Data bus drive, enable low while driving
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  // Flags of the selected FIFO
  output sfrcp_flags_s flags,
  // Static configuration
  input wire logic auto_mode,
  input wire logic [SFRCP_CNT_W-1:0] auto_commit_length,
  // Committed-packet report toward the endpoint side
  output logic commit_valid,
  output logic [SFRCP_SEL_W-1:0] commit_fifo,
  output logic [SFRCP_CNT_W-1:0] commit_bytes,
  output logic commit_auto
);

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  logic [7:0] pins_raw;
  logic [7:0] pins_s;
  logic [7:0] pins_rise;
  logic [DATA_W-1:0] din_m_q;
  logic [DATA_W-1:0] din_q;

  assign pins_raw = {interface_clock, fifo_select, ctl_pins};

  sfrcp_edge_sync #(.WIDTH(8)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_s),
    .rise_out(pins_rise)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      din_m_q <= '0;
      din_q <= '0;
    end else begin
      din_m_q <= data_in;
      din_q <= din_m_q;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire link_edge = pins_rise[7];
  wire [SFRCP_SEL_W-1:0] sel = pins_s[6:5];
  wire cs = pins_s[4];
  wire oe = pins_s[3];
  wire rd = pins_s[2];
  wire wr = pins_s[1];
  wire pe = pins_s[0];

  // A strobe without chip select is ignored entirely.
  wire rd_go = link_edge & cs & rd;
  wire wr_go = link_edge & cs & wr;
  wire pe_go = link_edge & cs & pe;

  // ---------------------------------------------------------------
  // FIFO storage
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [SFRCP_NUM_FIFOS][DEPTH];
  logic [SFRCP_PTR_W-1:0] rptr_q [SFRCP_NUM_FIFOS];
  logic [SFRCP_PTR_W-1:0] wptr_q [SFRCP_NUM_FIFOS];
  logic [SFRCP_CNT_W-1:0] cnt_q [SFRCP_NUM_FIFOS];
  logic [SFRCP_CNT_W-1:0] pkt_q [SFRCP_NUM_FIFOS];
  logic [SFRCP_NUM_FIFOS-1:0] just_auto_q;

  function automatic logic [SFRCP_PTR_W-1:0] ptr_inc(input logic [SFRCP_PTR_W-1:0] p);
    ptr_inc = (p == SFRCP_PTR_W'(DEPTH - 1)) ? SFRCP_PTR_RST : p + 1'b1;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < SFRCP_NUM_FIFOS; gi++) begin : g_fifo
      wire hit = (sel == SFRCP_SEL_W'(gi));
      wire f_empty = (cnt_q[gi] == SFRCP_CNT_RST);
      wire f_full = (cnt_q[gi] == SFRCP_CNT_W'(DEPTH));
      wire do_rd = rd_go & hit & ~f_empty;
      wire do_wr = wr_go & hit & ~f_full;
      wire [SFRCP_CNT_W-1:0] pkt_nx = pkt_q[gi] + SFRCP_CNT_W'(do_wr);
      wire auto_hit = auto_mode & do_wr & (pkt_nx == auto_commit_length);
      // A commit one edge after an auto commit is dropped; the word stays.
      wire man_ok = pe_go & hit & ~just_auto_q[gi] & (pkt_nx != SFRCP_CNT_RST);

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          // Clearing storage keeps the prefetched head known before the first write.
          mem_q[gi] <= '{default: '0};
          rptr_q[gi] <= SFRCP_PTR_RST;
          wptr_q[gi] <= SFRCP_PTR_RST;
          cnt_q[gi] <= SFRCP_CNT_RST;
          pkt_q[gi] <= SFRCP_CNT_RST;
          just_auto_q[gi] <= 1'b0;
        end else begin
          if (do_rd) begin
            rptr_q[gi] <= ptr_inc(rptr_q[gi]);
          end
          if (do_wr) begin
            mem_q[gi][wptr_q[gi]] <= din_q;
            wptr_q[gi] <= ptr_inc(wptr_q[gi]);
          end
          cnt_q[gi] <= cnt_q[gi] + SFRCP_CNT_W'(do_wr) - SFRCP_CNT_W'(do_rd);
          pkt_q[gi] <= (auto_hit | man_ok) ? SFRCP_CNT_RST : pkt_nx;
          if (link_edge) begin
            just_auto_q[gi] <= auto_hit;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Commit report
  // ---------------------------------------------------------------
  wire [SFRCP_CNT_W-1:0] sel_pkt_nx = pkt_q[sel] + SFRCP_CNT_W'(wr_go & ~flags.full);
  wire sel_auto = auto_mode & wr_go & ~flags.full & (sel_pkt_nx == auto_commit_length);
  wire sel_man = pe_go & ~just_auto_q[sel] & (sel_pkt_nx != SFRCP_CNT_RST);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      commit_valid <= 1'b0;
      commit_fifo <= '0;
      commit_bytes <= SFRCP_CNT_RST;
      commit_auto <= 1'b0;
    end else begin
      commit_valid <= sel_auto | sel_man;
      commit_fifo <= sel;
      commit_bytes <= sel_pkt_nx;
      commit_auto <= sel_auto;
    end
  end

  // ---------------------------------------------------------------
  // Bus and flags
  // ---------------------------------------------------------------
  // Head entry is always prefetched from the current read pointer, so the
  // bus follows select and pointer with no extra pop; a one-cycle output
  // register keeps the pads glitch free at the cost of one ref_clk of delay.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else begin
      data_out <= mem_q[sel][rptr_q[sel]];
      data_oe_n <= ~oe;
    end
  end

  assign flags.empty = (cnt_q[sel] == SFRCP_CNT_RST);
  assign flags.full = (cnt_q[sel] == SFRCP_CNT_W'(DEPTH));

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_OE_NO_POP: assert property (@(posedge ref_clk) disable iff (rst)
    (!rd_go) |=> (rptr_q[sel] == $past(rptr_q[sel]) || sel != $past(sel)))
    else $error("Read pointer moved without a read.");
  AST_RD_ADV: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_go && !flags.empty) |=> (rptr_q[$past(sel)] == ptr_inc($past(rptr_q[sel]))))
    else $error("Read edge did not advance pointer.");
  AST_NO_CS: assert property (@(posedge ref_clk) disable iff (rst)
    (link_edge && !cs && sel == $past(sel)) |=> $stable(cnt_q[sel]))
    else $error("Strobe acted without chip select.");
  AST_OE_DRIVE: assert property (@(posedge ref_clk) disable iff (rst)
    oe |=> !data_oe_n)
    else $error("Bus not driven with output enable.");
  AST_OE_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    !oe |=> data_oe_n)
    else $error("Bus driven without output enable.");
  AST_PREFETCH: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> data_out == $past(mem_q[sel][rptr_q[sel]]))
    else $error("Bus does not show head entry.");
  AST_AUTO: assert property (@(posedge ref_clk) disable iff (rst)
    sel_auto |=> commit_valid && commit_auto && commit_bytes == $past(auto_commit_length))
    else $error("Auto commit missing.");
  AST_LOST: assert property (@(posedge ref_clk) disable iff (rst)
    (pe_go && just_auto_q[sel] && !sel_auto) |=> !commit_valid)
    else $error("Early commit was not dropped.");
  AST_WR_CNT: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_go && !rd_go && !flags.full) |=> cnt_q[$past(sel)] == $past(cnt_q[sel]) + 1'b1)
    else $error("Write did not count.");

  COV_BURST: cover property (@(posedge ref_clk) disable iff (rst) rd_go ##[1:20] rd_go);
  COV_AUTO: cover property (@(posedge ref_clk) disable iff (rst) sel_auto);
  COV_MAN: cover property (@(posedge ref_clk) disable iff (rst) sel_man);
  COV_LOST: cover property (@(posedge ref_clk) disable iff (rst) pe_go && just_auto_q[sel]);

endmodule

// ### hdl/sfrcp_pkg.sv
// Package: shared constants and carrier types for the slave FIFO read/commit port.
package sfrcp_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int SFRCP_NUM_FIFOS = 4;
  localparam int SFRCP_SEL_W = 2;
  localparam int SFRCP_DATA_W = 16;
  localparam int SFRCP_DEPTH = 16;
  localparam int SFRCP_PTR_W = 4;
  localparam int SFRCP_CNT_W = 5;

  // ---------------------------------------------------------------
  // Reset values and defaults
  // ---------------------------------------------------------------
  localparam logic [SFRCP_CNT_W-1:0] SFRCP_AUTO_LEN_RST = 5'h08;
  localparam logic [SFRCP_PTR_W-1:0] SFRCP_PTR_RST = 4'h0;
  localparam logic [SFRCP_CNT_W-1:0] SFRCP_CNT_RST = 5'h00;

  // ---------------------------------------------------------------
  // Timing: select setup to sampling edge
  // ---------------------------------------------------------------
  localparam int SFRCP_CLK_MHZ = 50;
  localparam int SFRCP_SEL_SETUP_NS = 25;
  localparam int SFRCP_SEL_SETUP_CYC =
    (SFRCP_SEL_SETUP_NS * SFRCP_CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic chip_select;
    logic output_enable;
    logic read_strobe;
    logic write_strobe;
    logic commit_strobe;
  } sfrcp_ctl_s;

  typedef struct packed {
    logic empty;
    logic full;
  } sfrcp_flags_s;

endpackage

// ### hdl/sfrcp_edge_sync.sv
// Two-stage synchroniser with rising-edge detect on the second stage output.
`timescale 1ns/100ps
module sfrcp_edge_sync
  import sfrcp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Asynchronous input
  input wire logic [WIDTH-1:0] async_in,
  // Synchronised level and rising edge
  output logic [WIDTH-1:0] sync_out,
  output logic [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sync_out = sync_q;
  assign rise_out = sync_q & ~prev_q;

endmodule

// ### verif/sfrcp_master_model.sv
// Behavioural external master that drives the link clock and the slave FIFO pins.
`timescale 1ns/100ps
module sfrcp_master_model
  import sfrcp_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Pins toward the port
  output logic interface_clock,
  output logic [SFRCP_SEL_W-1:0] fifo_select,
  output sfrcp_ctl_s ctl_pins,
  output logic [SFRCP_DATA_W-1:0] data_in
);
  initial begin
    interface_clock = 1'b0;
    fifo_select = 2'h0;
    ctl_pins = '0;
    data_in = 16'h0000;
  end

  // Pins settle four ref_clk cycles (80 ns) before the rising edge, well past select setup.
  // The link clock stands still between calls, as a real master gates it outside frames.
  task automatic link_cycle(input logic [1:0] sel, input sfrcp_ctl_s ctl,
                            input logic [15:0] wd);
    @(posedge ref_clk);
    fifo_select <= sel;
    ctl_pins <= ctl;
    data_in <= ctl.write_strobe ? wd : ~data_in;
    repeat (4) @(posedge ref_clk);
    interface_clock <= 1'b1;
    repeat (4) @(posedge ref_clk);
    interface_clock <= 1'b0;
  endtask

  task automatic set_sel(input logic [1:0] sel);
    @(posedge ref_clk);
    fifo_select <= sel;
  endtask
endmodule

// ### verif/sfrcp_port_tb.sv
// Self-checking bench for the slave FIFO read/commit port.
`timescale 1ns/100ps
module sfrcp_port_tb
  import sfrcp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic auto_mode = 1'b0;
  logic [SFRCP_CNT_W-1:0] auto_len = 5'h04;
  logic interface_clock;
  logic [SFRCP_SEL_W-1:0] fifo_select, commit_fifo;
  sfrcp_ctl_s ctl_pins;
  sfrcp_flags_s flags;
  logic [SFRCP_DATA_W-1:0] data_in, data_out;
  logic data_oe_n, commit_valid, commit_auto;
  logic [SFRCP_CNT_W-1:0] commit_bytes;
  int bad_count = 0;
  int comparisons = 0;
  int n_commits = 0;
  logic [7:0] last_commit = 8'h00;
  localparam logic [4:0] C_IDLE = 5'h00, C_OE = 5'h18, C_RD = 5'h1c, C_RDX = 5'h0c;
  localparam logic [4:0] C_WR = 5'h12, C_WRPE = 5'h13, C_PE = 5'h11;

  always #10 ref_clk = ~ref_clk;

  // Commit pulses last one cycle, so they are logged here rather than polled.
  always @(posedge ref_clk) begin
    if (commit_valid === 1'b1) begin
      n_commits <= n_commits + 1;
      last_commit <= {commit_fifo, commit_auto, commit_bytes};
    end
  end

  sfrcp_master_model u_sfrcp_master_model (
    .ref_clk(ref_clk), .interface_clock(interface_clock), .fifo_select(fifo_select),
    .ctl_pins(ctl_pins), .data_in(data_in)
  );

  sfrcp_port u_sfrcp_port (
    .ref_clk(ref_clk), .rst(rst), .interface_clock(interface_clock),
    .fifo_select(fifo_select), .ctl_pins(ctl_pins), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .flags(flags),
    .auto_mode(auto_mode), .auto_commit_length(auto_len),
    .commit_valid(commit_valid), .commit_fifo(commit_fifo),
    .commit_bytes(commit_bytes), .commit_auto(commit_auto)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input logic [1:0] sel, input logic [4:0] ctl, input logic [15:0] wd);
    u_sfrcp_master_model.link_cycle(sel, ctl, wd);
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic t_reset();
    check(data_oe_n, 1'b1, "bus drive after reset");
    check(flags, 2'h2, "flags after reset");
    check(commit_valid, 1'b0, "commit after reset");
    $display("test reset done");
  endtask

  task automatic t_write_select();
    for (int k = 0; k < 4; k++) begin
      cyc(2'h1, C_WR, 16'h1a00 + 16'(k));
    end
    u_sfrcp_master_model.set_sel(2'h0);
    repeat (4) @(posedge ref_clk);
    check(flags, 2'h2, "fifo 0 flags");
    u_sfrcp_master_model.set_sel(2'h1);
    repeat (4) @(posedge ref_clk);
    check(flags, 2'h0, "fifo 1 flags");
    $display("test write and select done");
  endtask

  task automatic t_full();
    for (int k = 0; k < 16; k++) begin
      cyc(2'h0, C_WR, 16'h0f00 + 16'(k));
    end
    check(flags, 2'h1, "fifo 0 full");
    cyc(2'h0, C_WR, 16'h0f10);
    check(flags, 2'h1, "write refused when full");
    $display("test full done");
  endtask

  task automatic t_oe_read();
    cyc(2'h1, C_OE, 16'h0);
    check(data_oe_n, 1'b0, "bus driven");
    check(data_out, 16'h1a00, "prefetched head");
    cyc(2'h1, C_IDLE, 16'h0);
    check(data_oe_n, 1'b1, "bus released");
    cyc(2'h1, C_RDX, 16'h0);
    cyc(2'h1, C_OE, 16'h0);
    check(data_out, 16'h1a00, "head kept");
    for (int k = 1; k < 4; k++) begin
      cyc(2'h1, C_RD, 16'h0);
      check(data_out, 16'h1a00 + 32'(k), "burst entry");
    end
    cyc(2'h1, C_RD, 16'h0);
    check(flags, 2'h2, "fifo drained");
    $display("test output enable and read done");
  endtask

  task automatic t_auto();
    auto_mode <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      cyc(2'h2, C_WR, 16'h2b00 + 16'(k));
    end
    check(n_commits, 1, "auto commit count");
    check(last_commit, {2'h2, 1'b1, 5'h04}, "auto commit");
    cyc(2'h2, C_WRPE, 16'h2b04);
    check(n_commits, 1, "early commit");
    cyc(2'h2, C_PE, 16'h0);
    check(n_commits, 2, "late commit count");
    check(last_commit, {2'h2, 1'b0, 5'h01}, "short packet");
    $display("test auto commit done");
  endtask

  task automatic t_same_edge();
    cyc(2'h3, C_WR, 16'h3c00);
    cyc(2'h3, C_WRPE, 16'h3c01);
    check(n_commits, 3, "same edge commit count");
    check(last_commit, {2'h3, 1'b0, 5'h02}, "same edge packet");
    $display("test same edge commit done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The whole sequence takes about 10 us; a hang is cut off well past that.
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_write_select();
    t_full();
    t_oe_read();
    t_auto();
    t_same_edge();
    report_and_stop();
  end
endmodule
